// *** design/line_break_detect.sv ***
/*
 * Break detector: watches the (possibly looped) receive level and gives
 * one pulse when it has stayed low for longer than the longest frame.
 * Assumes bit_tick pulses once per bit period, synchronous to pclk.
 */
`timescale 1ns/10ps
module line_break_detect (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Line side
    input  wire logic rx_level,
    input  wire logic bit_tick,
    // Event out
    output logic      break_pulse
);

    uart_status_pkg::brk_state_t state_reg;
    uart_status_pkg::brk_state_t state_next;
    logic [3:0]                  low_count_reg;
    logic [3:0]                  low_count_next;
    logic                        pulse_next;

    // Count whole bit times spent low; one pulse per break, then wait for idle
    always_comb begin
        state_next     = state_reg;
        low_count_next = low_count_reg;
        pulse_next     = 1'b0;
        case (state_reg)
            uart_status_pkg::BRK_IDLE: begin
                low_count_next = 4'h0;
                if (!rx_level) begin
                    state_next = uart_status_pkg::BRK_COUNTING;
                end
            end
            uart_status_pkg::BRK_COUNTING: begin
                if (rx_level) begin
                    state_next = uart_status_pkg::BRK_IDLE;
                end else if (bit_tick) begin
                    if (low_count_reg == uart_status_pkg::BREAK_BIT_TIMES) begin
                        state_next = uart_status_pkg::BRK_HELD;
                        pulse_next = 1'b1;
                    end else begin
                        low_count_next = low_count_reg + 4'h1;
                    end
                end
            end
            uart_status_pkg::BRK_HELD: begin
                if (rx_level) begin
                    state_next = uart_status_pkg::BRK_IDLE;
                end
            end
            default: begin
                state_next = uart_status_pkg::BRK_IDLE;
            end
        endcase
    end

    // State, counter and pulse flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= uart_status_pkg::BRK_IDLE;
            low_count_reg <= 4'h0;
            break_pulse   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            low_count_reg <= low_count_next;
            break_pulse   <= pulse_next;
        end
    end

endmodule

// *** design/uart_status_modem_irq_enable.sv ***
/*
 * UART modem/loopback control, line status and interrupt enable registers
 * behind an APB slave, with the status flags, the pin drivers and the
 * prioritised interrupt request.
 * Assumes the transmitter, receiver, divisor latches and line control
 * live elsewhere and report to this block through one-cycle pulses and
 * levels synchronous to pclk.
 */
`timescale 1ns/10ps
module uart_status_modem_irq_enable (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Shared with line control and divisor logic
    input  wire logic        divisor_access_select,
    input  wire logic        bit_tick,
    // Transmitter events
    input  wire logic        tx_write,
    input  wire logic        tx_holding_taken,
    input  wire logic        tx_shift_busy,
    input  wire logic        shifter_tx_bit,
    // Receiver events
    input  wire logic        rx_char_loaded,
    input  wire logic        rx_read,
    input  wire logic        stop_bit_bad,
    input  wire logic        parity_bad,
    // Interrupt identification and modem status
    input  wire logic        ident_read,
    input  wire logic        modem_status_pending,
    output logic       [2:0] irq_ident,
    output logic             irq_out,
    // Serial pins and receiver feed
    input  wire logic        serial_rx_in,
    output logic             serial_tx_out,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             rx_line_to_receiver
);

    // Control registers
    logic       loop_reg;
    logic       rts_reg;
    logic       dtr_reg;
    logic [2:0] ien_reg;

    // Status flags
    logic       dr_reg;
    logic       oe_reg;
    logic       pe_reg;
    logic       fe_reg;
    logic       bi_reg;
    logic       tx_holding_empty_reg;
    logic       transmitter_fully_empty_reg;
    logic       txe_acked_reg;

    // Bus decode
    wire        setup_phase = psel & ~penable;
    wire        access_done = psel & penable & pready;
    wire        sel_lsr     = (paddr == uart_status_pkg::LINE_STATUS_ADDR);
    wire        sel_ien     = (paddr == uart_status_pkg::IRQ_ENABLE_ADDR);
    wire        sel_mcr     = (paddr == uart_status_pkg::MODEM_LOOP_ADDR);
    wire        addr_hit    = sel_lsr | sel_ien | sel_mcr;
    // The enable register shares its address with the divisor high byte
    wire        ien_visible = sel_ien & ~divisor_access_select;
    wire        wr_mcr      = access_done & pwrite & sel_mcr;
    wire        wr_ien      = access_done & pwrite & ien_visible;
    wire        lsr_read    = access_done & ~pwrite & sel_lsr;

    // Assembled register views; reserved bits read as zero
    wire  [7:0] lsr_view = {1'b0, transmitter_fully_empty_reg, tx_holding_empty_reg, bi_reg, fe_reg, pe_reg, oe_reg, dr_reg};
    wire  [7:0] mcr_view = {3'h0, loop_reg, 2'h0, rts_reg, dtr_reg};
    wire  [7:0] ien_view = {5'h00, ien_reg};
    wire  [7:0] rd_byte  = sel_lsr     ? lsr_view :
                           sel_mcr     ? mcr_view :
                           ien_visible ? ien_view : 8'h00;

    // Zero-wait answer: pready rises in the access phase of every transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_hit;
            prdata  <= (setup_phase & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Control writes keep only the defined bits, so stray ones do no harm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_reg <= uart_status_pkg::MODEM_LOOP_RESET[uart_status_pkg::MCR_LOOP_BIT];
            rts_reg  <= uart_status_pkg::MODEM_LOOP_RESET[uart_status_pkg::MCR_RTS_BIT];
            dtr_reg  <= uart_status_pkg::MODEM_LOOP_RESET[uart_status_pkg::MCR_DTR_BIT];
            ien_reg  <= uart_status_pkg::IRQ_ENABLE_RESET[2:0];
        end else begin
            if (wr_mcr) begin
                loop_reg <= pwdata[uart_status_pkg::MCR_LOOP_BIT];
                rts_reg  <= pwdata[uart_status_pkg::MCR_RTS_BIT];
                dtr_reg  <= pwdata[uart_status_pkg::MCR_DTR_BIT];
            end
            if (wr_ien) begin
                ien_reg <= pwdata[2:0];
            end
        end
    end

    // Pins: loopback parks the line high and feeds the shifter back inward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_tx_out       <= 1'b1;
            rts_n               <= 1'b1;
            dtr_n               <= 1'b1;
            rx_line_to_receiver <= 1'b1;
        end else begin
            serial_tx_out       <= loop_reg | shifter_tx_bit;
            rts_n               <= ~rts_reg;
            dtr_n               <= ~dtr_reg;
            rx_line_to_receiver <= loop_reg ? shifter_tx_bit : serial_rx_in;
        end
    end

    // Break detection works on the line the receiver actually sees
    logic break_pulse;

    line_break_detect u_break (
        .pclk        (pclk),
        .presetn     (presetn),
        .rx_level    (rx_line_to_receiver),
        .bit_tick    (bit_tick),
        .break_pulse (break_pulse)
    );

    // Transmit side: empty flags fall on a write and return as data moves on
    wire tx_holding_empty_next = tx_holding_taken | (tx_holding_empty_reg & ~tx_write);
    wire transmitter_fully_empty_next = tx_holding_empty_next & ~tx_shift_busy & ~tx_write;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_holding_empty_reg <= uart_status_pkg::LINE_STATUS_RESET[uart_status_pkg::LSR_TX_HOLDING_EMPTY_BIT];
            transmitter_fully_empty_reg <= uart_status_pkg::LINE_STATUS_RESET[uart_status_pkg::LSR_TRANSMITTER_FULLY_EMPTY_BIT];
        end else begin
            tx_holding_empty_reg <= tx_holding_empty_next;
            transmitter_fully_empty_reg <= transmitter_fully_empty_next;
        end
    end

    // Only flags that this read actually returned are cleared; one that rose
    // after the setup edge missed the returned byte and waits for the next read
    wire oe_shown = prdata[uart_status_pkg::LSR_OE_BIT];
    wire pe_shown = prdata[uart_status_pkg::LSR_PE_BIT];
    wire fe_shown = prdata[uart_status_pkg::LSR_FE_BIT];
    wire bi_shown = prdata[uart_status_pkg::LSR_BI_BIT];

    // Receive flags: a new event in the clearing cycle wins over the clear
    wire dr_next = rx_char_loaded | (dr_reg & ~rx_read);
    wire oe_next = (rx_char_loaded & dr_reg) | (oe_reg & ~(lsr_read & oe_shown));
    wire pe_next = parity_bad | (pe_reg & ~(lsr_read & pe_shown));
    wire fe_next = stop_bit_bad | (fe_reg & ~(lsr_read & fe_shown));
    wire bi_next = break_pulse | (bi_reg & ~(lsr_read & bi_shown));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dr_reg <= 1'b0;
            oe_reg <= 1'b0;
            pe_reg <= 1'b0;
            fe_reg <= 1'b0;
            bi_reg <= 1'b0;
        end else begin
            dr_reg <= dr_next;
            oe_reg <= oe_next;
            pe_reg <= pe_next;
            fe_reg <= fe_next;
            bi_reg <= bi_next;
        end
    end

    // Interrupt sources; break is not among the line-error causes
    wire line_pend = ien_reg[uart_status_pkg::IEN_LINE_BIT] & (oe_reg | pe_reg | fe_reg);
    wire rx_pend   = ien_reg[uart_status_pkg::IEN_RXFULL_BIT] & dr_reg;
    wire tx_pend   = ien_reg[uart_status_pkg::IEN_TXEMPTY_BIT] & tx_holding_empty_reg & ~txe_acked_reg;

    // Fixed priority: line errors, receive full, transmit empty, modem
    wire [2:0] ident_next = line_pend            ? uart_status_pkg::IDENT_LINE    :
                            rx_pend              ? uart_status_pkg::IDENT_RXFULL  :
                            tx_pend              ? uart_status_pkg::IDENT_TXEMPTY :
                            modem_status_pending ? uart_status_pkg::IDENT_MODEM   :
                                                   uart_status_pkg::IDENT_NONE;

    // Reading the identification while it names transmit-empty acknowledges
    // it; the next transmit write re-arms it, so one ack covers one empty spell
    wire txe_ack_next = (ident_read & (irq_ident == uart_status_pkg::IDENT_TXEMPTY))
                      | (txe_acked_reg & ~tx_write);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txe_acked_reg <= 1'b0;
            irq_ident     <= uart_status_pkg::IDENT_NONE;
            irq_out       <= 1'b0;
        end else begin
            txe_acked_reg <= txe_ack_next;
            irq_ident     <= ident_next;
            irq_out       <= ~ident_next[0];
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence tx_loaded_s;
        tx_write && !tx_holding_taken;
    endsequence

    sequence lsr_read_s;
        lsr_read && !stop_bit_bad && !parity_bad;
    endsequence

    loop_forces_high_a: assert property (loop_reg |=> serial_tx_out)
        else $error("Transmit output not high in loopback");

    rts_inverted_a: assert property (##1 rts_n == !$past(rts_reg))
        else $error("Request-to-send pin does not follow control bit inverted");

    dtr_inverted_a: assert property (##1 dtr_n == !$past(dtr_reg))
        else $error("Terminal-ready pin does not follow control bit inverted");

    transmitter_fully_empty_needs_tx_holding_empty_a: assert property (transmitter_fully_empty_reg |-> tx_holding_empty_reg && !$past(tx_write))
        else $error("Transmitter empty set while holding register full");

    tx_holding_empty_write_clear_a: assert property (tx_loaded_s |=> !tx_holding_empty_reg && !transmitter_fully_empty_reg)
        else $error("Empty flags did not clear on transmit write");

    overrun_set_a: assert property (rx_char_loaded && dr_reg |=> oe_reg && dr_reg)
        else $error("Overrun not flagged on unread character");

    data_ready_a: assert property (rx_read && !rx_char_loaded |=> !dr_reg)
        else $error("Data ready not cleared by receive read");

    error_clear_a: assert property (lsr_read_s
                                    |=> !(pe_reg && $past(pe_shown)) && !(fe_reg && $past(fe_shown)))
        else $error("Error flags survive a status read");

    line_irq_a: assert property (ien_reg[2] && (oe_reg || fe_reg || pe_reg)
                                 |=> irq_out && irq_ident == 3'h6)
        else $error("Line error interrupt missing or wrong priority");

    rx_irq_a: assert property (ien_reg[0] && dr_reg && !line_pend |=> irq_out && irq_ident == 3'h4)
        else $error("Receive full interrupt missing");

    ien_hidden_a: assert property (access_done && pwrite && sel_ien && divisor_access_select
                                   |=> $stable(ien_reg))
        else $error("Enable register written while divisor access set");

    lsr_reset_a: assert property ($rose(presetn) |-> lsr_view == 8'h60)
        else $error("Line status not at reset value");

    error_kept_a: assert property (lsr_read && pe_reg && !pe_shown |=> pe_reg)
        else $error("Parity flag cleared before it was returned");

    tx_holding_empty_set_a: assert property (tx_holding_taken |=> tx_holding_empty_reg)
        else $error("Holding empty not set when the shifter took the byte");

    dr_set_a: assert property (rx_char_loaded |=> dr_reg)
        else $error("Data ready not set on a loaded character");

    break_sets_a: assert property (break_pulse |=> bi_reg)
        else $error("Break flag not set after a break");

    tx_irq_a: assert property (tx_pend && !line_pend && !rx_pend
                               |=> irq_out && irq_ident == 3'h2)
        else $error("Transmit empty interrupt missing or wrong priority");

    modem_irq_a: assert property (modem_status_pending && !line_pend && !rx_pend && !tx_pend
                                  |=> irq_out && irq_ident == 3'h0)
        else $error("Modem status interrupt missing or wrong priority");

endmodule

// *** design/uart_status_pkg.sv ***
/*
 * Shared constants for the UART modem-control, line-status and
 * interrupt-enable block: byte addresses, bit positions, reset values,
 * interrupt identification codes and the break detector states.
 * Assumes a 32-bit APB register bus and a baud-rate tick from the
 * divisor logic that sits outside this block.
 */
package uart_status_pkg;

    // Byte addresses of the registers kept here
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h0fff0814;
    localparam logic [31:0] IRQ_ENABLE_ADDR  = 32'hffff0804;
    localparam logic [31:0] MODEM_LOOP_ADDR  = 32'hffff0810;

    // Modem and loopback control fields
    localparam int MCR_DTR_BIT  = 0;
    localparam int MCR_RTS_BIT  = 1;
    localparam int MCR_LOOP_BIT = 4;

    // Line status fields
    localparam int LSR_DR_BIT   = 0;
    localparam int LSR_OE_BIT   = 1;
    localparam int LSR_PE_BIT   = 2;
    localparam int LSR_FE_BIT   = 3;
    localparam int LSR_BI_BIT   = 4;
    localparam int LSR_TX_HOLDING_EMPTY_BIT = 5;
    localparam int LSR_TRANSMITTER_FULLY_EMPTY_BIT = 6;

    // Interrupt enable fields
    localparam int IEN_RXFULL_BIT = 0;
    localparam int IEN_TXEMPTY_BIT = 1;
    localparam int IEN_LINE_BIT   = 2;

    // Reset values
    localparam logic [7:0] LINE_STATUS_RESET = 8'h60;
    localparam logic [7:0] IRQ_ENABLE_RESET  = 8'h00;
    localparam logic [7:0] MODEM_LOOP_RESET  = 8'h00;

    // Identification codes: bits 2:1 source, bit 0 low while pending
    localparam logic [2:0] IDENT_NONE    = 3'h1;
    localparam logic [2:0] IDENT_LINE    = 3'h6;
    localparam logic [2:0] IDENT_RXFULL  = 3'h4;
    localparam logic [2:0] IDENT_TXEMPTY = 3'h2;
    localparam logic [2:0] IDENT_MODEM   = 3'h0;

    // Longest frame in bit times: start, 8 data, parity, 2 stop
    localparam logic [3:0] BREAK_BIT_TIMES = 4'hc;

    // Break detector states, Gray coded along idle -> counting -> held
    typedef enum logic [1:0] {
        BRK_IDLE     = 2'b00,
        BRK_COUNTING = 2'b01,
        BRK_HELD     = 2'b11
    } brk_state_t;

endpackage

// *** verif/serial_peer.sv ***
/*
 * Behavioural serial peer on the far side of the UART pins.
 * Assumes the bench asks for a break through hold_break; otherwise the
 * line idles at the mark level, as a real peer with a pull-up would.
 */
`timescale 1ns/10ps
module serial_peer (
    // Clock
    input  wire logic pclk,
    // Pins from the device
    input  wire logic serial_tx_out,
    input  wire logic rts_n,
    input  wire logic dtr_n,
    // Bench control
    input  wire logic hold_break,
    // Pin to the device
    output logic      serial_rx_in
);
    // Line is held low only while a break is asked for, so no stale level lingers
    always_ff @(posedge pclk) begin
        serial_rx_in <= !hold_break;
    end
    initial serial_rx_in = 1'b1;
endmodule

// *** verif/uart_status_modem_irq_enable_tb.sv ***
/*
 * Self-checking bench for the UART status, modem control and interrupt
 * enable block: APB tasks, event pulses and register expectations.
 * Assumes zero-wait APB answers and the peer model in serial_peer.sv.
 */
`timescale 1ns/10ps
module uart_status_modem_irq_enable_tb;
    localparam logic [31:0] LSR = uart_status_pkg::LINE_STATUS_ADDR;
    localparam logic [31:0] IEN = uart_status_pkg::IRQ_ENABLE_ADDR;
    localparam logic [31:0] MCR = uart_status_pkg::MODEM_LOOP_ADDR;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0]  ev;
    logic        busy, sbit, dsel, brk, msp, rxin, txo, rts_n, dtr_n, rxl, irq_out;
    logic [2:0]  irq_ident;
    int          err_total, check_count;

    uart_status_modem_irq_enable DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .divisor_access_select(dsel), .bit_tick(ev[7]), .tx_write(ev[0]), .tx_holding_taken(ev[1]),
        .tx_shift_busy(busy), .shifter_tx_bit(sbit), .rx_char_loaded(ev[2]), .rx_read(ev[3]),
        .stop_bit_bad(ev[4]), .parity_bad(ev[5]), .ident_read(ev[6]), .modem_status_pending(msp),
        .irq_ident(irq_ident), .irq_out(irq_out), .serial_rx_in(rxin), .serial_tx_out(txo),
        .rts_n(rts_n), .dtr_n(dtr_n), .rx_line_to_receiver(rxl));

    serial_peer peer (.pclk(pclk), .serial_tx_out(txo), .rts_n(rts_n), .dtr_n(dtr_n),
        .hold_break(brk), .serial_rx_in(rxin));

    // Free-running 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; a spare edge at the end keeps psel from toggling twice in one step
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) chk("pready", 32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(nm, rd, exp);
    endtask

    // One-cycle event pulse, then one quiet cycle
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, busy, dsel, brk, msp} = 8'h00;
        {paddr, pwdata, ev, sbit} = {32'h0, 32'h0, 8'h0, 1'b1};
        err_total = 0;
        check_count = 0;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        rdchk("lsr", LSR, 32'h60);
        rdchk("ien", IEN, 32'h0);
        rdchk("mcr", MCR, 32'h0);
        chk("ident", 32'(irq_ident), 32'h1);
        done("reset");
        // Handshake pins follow the control bits inverted; unused bits written as zero
        for (int v = 0; v < 4; v++) begin
            apb(MCR, 1'b1, 32'(v));
            tick(2);
            chk("rts_n", 32'(rts_n), v[1] ? 32'h0 : 32'h1);
            chk("dtr_n", 32'(dtr_n), v[0] ? 32'h0 : 32'h1);
        end
        rdchk("mcr", MCR, 32'h3);
        sbit <= 1'b0;
        apb(MCR, 1'b1, 32'h10);
        tick(2);
        chk("tx_loop", 32'(txo), 32'h1);
        chk("rx_loop", 32'(rxl), 32'h0);
        apb(MCR, 1'b1, 32'h0);
        tick(2);
        chk("tx_norm", 32'(txo), 32'h0);
        chk("rx_norm", 32'(rxl), 32'h1);
        sbit <= 1'b1;
        done("modem");
        // Read-only status and an unmapped address
        apb(LSR, 1'b1, 32'h0);
        rdchk("lsr_ro", LSR, 32'h60);
        apb(32'h00000100, 1'b0, 32'h0);
        chk("slverr", 32'(er), 32'h1);
        chk("unmapped", rd, 32'h0);
        done("readonly");
        // Transmit empties: holding empties before the shifter does
        pulse(0);
        rdchk("lsr_tx", LSR, 32'h00);
        busy <= 1'b1;
        pulse(1);
        rdchk("lsr_tx_holding_empty", LSR, 32'h20);
        busy <= 1'b0;
        tick(2);
        rdchk("lsr_transmitter_fully_empty", LSR, 32'h60);
        done("transmit");
        // Receive, overrun and error flags; error flags clear after the read returns them
        pulse(2);
        rdchk("lsr_dr", LSR, 32'h61);
        pulse(2);
        rdchk("lsr_oe", LSR, 32'h63);
        rdchk("lsr_oe_clr", LSR, 32'h61);
        pulse(3);
        rdchk("lsr_rd", LSR, 32'h60);
        pulse(4);
        pulse(5);
        rdchk("lsr_fe_pe", LSR, 32'h6c);
        rdchk("lsr_clr", LSR, 32'h60);
        // A parity error landing on the setup edge misses the returned byte and must survive the read
        fork
            apb(LSR, 1'b0, 32'h0);
            pulse(5);
        join
        chk("lsr_late", rd, 32'h60);
        rdchk("lsr_kept", LSR, 32'h64);
        rdchk("lsr_clr2", LSR, 32'h60);
        done("receive");
        // Break: twelve bit times low is still a frame, the thirteenth is not
        brk <= 1'b1;
        tick(4);
        repeat (12) pulse(7);
        rdchk("lsr_12", LSR, 32'h60);
        pulse(7);
        rdchk("lsr_bi", LSR, 32'h70);
        brk <= 1'b0;
        rdchk("lsr_bi_clr", LSR, 32'h60);
        done("break");
        // Line, receive and transmit sources pending, then cleared one at a time in priority order
        apb(IEN, 1'b1, 32'h7);
        pulse(2);
        pulse(5);
        tick(2);
        chk("id_line", 32'(irq_ident), 32'h6);
        chk("irq_on", 32'(irq_out), 32'h1);
        rdchk("lsr_pe", LSR, 32'h65);
        tick(3);
        chk("id_rx", 32'(irq_ident), 32'h4);
        pulse(3);
        tick(3);
        chk("id_tx", 32'(irq_ident), 32'h2);
        pulse(6);
        tick(3);
        chk("id_none", 32'(irq_ident), 32'h1);
        chk("irq_off", 32'(irq_out), 32'h0);
        // Modem status is the lowest source and shows once the others are quiet
        msp <= 1'b1;
        tick(2);
        chk("id_modem", 32'(irq_ident), 32'h0);
        chk("irq_modem", 32'(irq_out), 32'h1);
        msp <= 1'b0;
        apb(IEN, 1'b1, 32'h0);
        pulse(5);
        tick(3);
        chk("id_masked", 32'(irq_ident), 32'h1);
        rdchk("lsr_pe2", LSR, 32'h64);
        done("interrupts");
        // Enable register hidden behind the divisor latch
        dsel <= 1'b1;
        apb(IEN, 1'b1, 32'h7);
        chk("dl_err", 32'(er), 32'h0);
        rdchk("ien_hidden", IEN, 32'h0);
        dsel <= 1'b0;
        tick(1);
        rdchk("ien_kept", IEN, 32'h0);
        done("divisor");
        results();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        err_total++;
        results();
    end
endmodule
